// file: rtl/cetw_defs.vh
// constants for the trap, overflow, watch and interrupt exception unit
`ifndef CETW_DEFS_VH
`define CETW_DEFS_VH

// register byte offsets
`define CETW_OFS_STATUS   8'h00
`define CETW_OFS_CAUSE    8'h04
`define CETW_OFS_EPC      8'h08
`define CETW_OFS_WATCH_LO 8'h0C
`define CETW_OFS_WATCH_HI 8'h10

// status field positions
`define CETW_ST_IE        0
`define CETW_ST_EXL       1
`define CETW_ST_ERL       2
`define CETW_ST_IM_LO     8
`define CETW_ST_IM_HI     15
`define CETW_ST_DE        16

// cause field positions
`define CETW_CA_EXC_LO    2
`define CETW_CA_EXC_HI    6
`define CETW_CA_IP_LO     8
`define CETW_CA_IP_HI     15
`define CETW_CA_BD        31

// watch low field positions
`define CETW_WL_W         0
`define CETW_WL_R         1

// exception codes
`define CETW_EXC_INT      5'h00
`define CETW_EXC_OV       5'h0C
`define CETW_EXC_TR       5'h0D
`define CETW_EXC_WATCH    5'h17

// reset values and vector
`define CETW_STATUS_RST   32'h0000_0004
`define CETW_COMMON_VEC   32'h8000_0180

// trap condition selectors
`define CETW_TC_GE        3'h0
`define CETW_TC_GEU       3'h1
`define CETW_TC_LT        3'h2
`define CETW_TC_LTU       3'h3
`define CETW_TC_EQ        3'h4
`define CETW_TC_NE        3'h5

`endif

// file: rtl/cetw_exc_unit.v
// trap, overflow, watch and interrupt exception unit with ahb-lite registers
`timescale 1ns/1ps
//
// What this block does
// - raise trap when trap condition is true
// - trap uses common vector and trap code
// - restart pc is branch pc in delay slot
// - signed add or subtract overflow raises exception
// - overflow uses common vector and overflow code
// - load or store at watch address raises watch
// - load and store match bits select access type
// - cache maintenance never raises a watch
// - exception level holds watch pending, sole mask
// - watch uses common vector and watch code
// - four request lines, nmi, eight interrupt conditions
// - fifth ordinary interrupt pending always reads zero
// - mask bits, global enable, level flags block interrupts
// - interrupt uses common vector and interrupt code
// - hardware pending bits follow live request lines
// - software bits cleared by writing zero
// - cache errors masked by disable bit or error level

`include "cetw_defs.vh"

module cetw_exc_unit (
    input  wire        hclk,
    input  wire        hresetn,
    input  wire        hsel,
    input  wire [31:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output reg         hreadyout,
    output reg  [31:0] hrdata,
    output reg         hresp,
    input  wire        ex_valid,
    input  wire [31:0] ex_pc,
    input  wire        ex_in_delay_slot,
    input  wire [31:0] ex_branch_pc,
    input  wire [63:0] ex_op_a,
    input  wire [63:0] ex_op_b,
    input  wire        ex_is_trap,
    input  wire [2:0]  ex_trap_cond,
    input  wire        ex_ovf_check,
    input  wire        ex_is_sub,
    input  wire        ex_is_64,
    input  wire        mem_valid,
    input  wire        mem_is_load,
    input  wire        mem_is_store,
    input  wire        mem_is_cache,
    input  wire [35:0] mem_paddr,
    input  wire [3:0]  int_req,
    input  wire        timer_irq,
    input  wire        nmi,
    input  wire        cache_err_req,
    output reg         exc_take,
    output reg  [31:0] exc_vector,
    output reg  [4:0]  exc_code,
    output reg  [31:0] exc_epc,
    output reg         cache_err_take,
    output reg         nmi_seen
);

// ----------------------------------------------------------------
// architectural state
// ----------------------------------------------------------------
reg  [31:0] status_q;
reg  [4:0]  code_q;
reg         bd_q;
reg  [1:0]  soft_ip_q;
reg  [31:0] epc_q;
reg  [31:0] watch_lo_q;
reg  [3:0]  watch_hi_q;
reg         watch_pend_q;
reg  [31:0] watch_pc_q;
reg         watch_bd_q;
reg         wr_pend_q;
reg  [7:0]  wr_addr_q;

wire        ie  = status_q[`CETW_ST_IE];
wire        exception_level_flag = status_q[`CETW_ST_EXL];
wire        error_level_flag = status_q[`CETW_ST_ERL];
wire [7:0]  im  = status_q[`CETW_ST_IM_HI:`CETW_ST_IM_LO];
wire        de  = status_q[`CETW_ST_DE];

// ----------------------------------------------------------------
// pending interrupts
// ----------------------------------------------------------------
// hardware bits are wires, not flops: no latching of requests
// fifth ordinary line tied low, it never requests
wire [7:0]  ip = {timer_irq, 1'b0, int_req, soft_ip_q};
wire        irq_any = (|(ip & im)) && ie && !exception_level_flag && !error_level_flag;

// ----------------------------------------------------------------
// overflow and trap condition
// ----------------------------------------------------------------
wire [63:0] op_b_eff = ex_is_sub ? ~ex_op_b : ex_op_b;
wire [63:0] sum64    = ex_op_a + op_b_eff + {63'h0, ex_is_sub};
wire        ovf64    = (ex_op_a[63] == op_b_eff[63]) && (sum64[63] != ex_op_a[63]);
// 32-bit results carry their sign in bit 31 of the same adder
wire        ovf32    = (ex_op_a[31] == op_b_eff[31]) && (sum64[31] != ex_op_a[31]);
wire        ovf_hit  = ex_valid && ex_ovf_check && (ex_is_64 ? ovf64 : ovf32);

wire        a_eq  = (ex_op_a == ex_op_b);
wire        a_ltu = (ex_op_a < ex_op_b);
wire        a_lt  = (ex_op_a[63] != ex_op_b[63]) ? ex_op_a[63] : a_ltu;
reg         trap_true;
always @* begin
    case (ex_trap_cond)
        `CETW_TC_GE:  trap_true = !a_lt;
        `CETW_TC_GEU: trap_true = !a_ltu;
        `CETW_TC_LT:  trap_true = a_lt;
        `CETW_TC_LTU: trap_true = a_ltu;
        `CETW_TC_EQ:  trap_true = a_eq;
        `CETW_TC_NE:  trap_true = !a_eq;
        default:      trap_true = 1'b0;
    endcase
end
wire        trap_hit = ex_valid && ex_is_trap && trap_true;

// ----------------------------------------------------------------
// watch match
// ----------------------------------------------------------------
// doubleword match: the low three address bits are ignored
wire        wadr_eq = (mem_paddr[35:3] == {watch_hi_q, watch_lo_q[31:3]});
wire        wtype   = (mem_is_load && watch_lo_q[`CETW_WL_R])
                   || (mem_is_store && watch_lo_q[`CETW_WL_W]);
wire        watch_hit = ex_valid && mem_valid && !mem_is_cache
                     && wadr_eq && wtype;

// restart address of the current instruction
wire [31:0] cur_epc = ex_in_delay_slot ? ex_branch_pc : ex_pc;

// ----------------------------------------------------------------
// exception selection, instruction faults before interrupts
// ----------------------------------------------------------------
// trap and overflow ignore the level flags: neither is maskable
reg         take_d;
reg  [4:0]  code_d;
reg  [31:0] epc_d;
reg         bd_d;
reg         wpend_set;
reg         wpend_clr;
always @* begin
    take_d    = 1'b0;
    code_d    = code_q;
    epc_d     = epc_q;
    bd_d      = bd_q;
    wpend_set = 1'b0;
    wpend_clr = 1'b0;
    if (trap_hit) begin
        take_d = 1'b1;
        code_d = `CETW_EXC_TR;
        epc_d  = cur_epc;
        bd_d   = ex_in_delay_slot;
    end else if (ovf_hit) begin
        take_d = 1'b1;
        code_d = `CETW_EXC_OV;
        epc_d  = cur_epc;
        bd_d   = ex_in_delay_slot;
    end else if (watch_hit && !exception_level_flag) begin
        take_d = 1'b1;
        code_d = `CETW_EXC_WATCH;
        epc_d  = cur_epc;
        bd_d   = ex_in_delay_slot;
    end else if (watch_pend_q && !exception_level_flag) begin
        take_d    = 1'b1;
        wpend_clr = 1'b1;
        code_d    = `CETW_EXC_WATCH;
        epc_d     = watch_pc_q;
        bd_d      = watch_bd_q;
    end else if (irq_any) begin
        take_d = 1'b1;
        code_d = `CETW_EXC_INT;
        epc_d  = cur_epc;
        bd_d   = ex_in_delay_slot;
    end
    // a watch seen at exception level waits instead of being lost
    if (watch_hit && exception_level_flag) begin
        wpend_set = 1'b1;
    end
end

// ----------------------------------------------------------------
// ahb-lite slave, zero wait states
// ----------------------------------------------------------------
// a read right behind a write still sees the old value
// response is fixed okay: no access here can fail
wire        acc    = hsel && htrans[1] && hready;
wire [7:0]  a_ofs  = haddr[7:0];
wire        wr_now = wr_pend_q;

reg  [31:0] rd_d;
always @* begin
    rd_d = 32'h0000_0000;
    if (a_ofs == `CETW_OFS_STATUS) begin
        rd_d = status_q;
    end else if (a_ofs == `CETW_OFS_CAUSE) begin
        rd_d[`CETW_CA_BD]                      = bd_q;
        rd_d[`CETW_CA_IP_HI:`CETW_CA_IP_LO]    = ip;
        rd_d[`CETW_CA_EXC_HI:`CETW_CA_EXC_LO]  = code_q;
    end else if (a_ofs == `CETW_OFS_EPC) begin
        rd_d = epc_q;
    end else if (a_ofs == `CETW_OFS_WATCH_LO) begin
        rd_d = {watch_lo_q[31:3], 1'b0, watch_lo_q[1:0]};
    end else if (a_ofs == `CETW_OFS_WATCH_HI) begin
        rd_d = {28'h0000000, watch_hi_q};
    end
end

always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        hreadyout <= 1'b1;
        hresp     <= 1'b0;
        hrdata    <= 32'h0000_0000;
        wr_pend_q <= 1'b0;
        wr_addr_q <= 8'h00;
    end else begin
        hreadyout <= 1'b1;
        hresp     <= 1'b0;
        wr_pend_q <= acc && hwrite;
        if (acc) begin
            wr_addr_q <= a_ofs;
        end
        if (acc && !hwrite) begin
            hrdata <= rd_d;
        end
    end
end

// ----------------------------------------------------------------
// register and exception state update
// ----------------------------------------------------------------
// hardware exception entry overrides a same-cycle software write
// only the two soft pending bits take writes in the cause word
always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        status_q     <= `CETW_STATUS_RST;
        code_q       <= 5'h00;
        bd_q         <= 1'b0;
        soft_ip_q    <= 2'h0;
        epc_q        <= 32'h0000_0000;
        watch_lo_q   <= 32'h0000_0000;
        watch_hi_q   <= 4'h0;
        watch_pend_q <= 1'b0;
        watch_pc_q   <= 32'h0000_0000;
        watch_bd_q   <= 1'b0;
    end else begin
        if (wr_now && wr_addr_q == `CETW_OFS_STATUS) begin
            status_q <= {15'h0000, hwdata[16], hwdata[15:8], 5'h00, hwdata[2:0]};
        end else if (wr_now && wr_addr_q == `CETW_OFS_CAUSE) begin
            soft_ip_q <= hwdata[`CETW_CA_IP_LO+1:`CETW_CA_IP_LO];
        end else if (wr_now && wr_addr_q == `CETW_OFS_EPC) begin
            epc_q <= hwdata;
        end else if (wr_now && wr_addr_q == `CETW_OFS_WATCH_LO) begin
            watch_lo_q <= {hwdata[31:3], 1'b0, hwdata[1:0]};
        end else if (wr_now && wr_addr_q == `CETW_OFS_WATCH_HI) begin
            watch_hi_q <= hwdata[3:0];
        end
        if (take_d) begin
            status_q[`CETW_ST_EXL] <= 1'b1;
            code_q <= code_d;
            epc_q  <= epc_d;
            bd_q   <= bd_d;
        end
        // new match wins over the clear of an older one
        if (wpend_set) begin
            watch_pend_q <= 1'b1;
            watch_pc_q   <= cur_epc;
            watch_bd_q   <= ex_in_delay_slot;
        end else if (wpend_clr) begin
            watch_pend_q <= 1'b0;
        end
    end
end

// ----------------------------------------------------------------
// registered outputs to the pipeline
// ----------------------------------------------------------------
always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        exc_take       <= 1'b0;
        exc_vector     <= 32'h0000_0000;
        exc_code       <= 5'h00;
        exc_epc        <= 32'h0000_0000;
        cache_err_take <= 1'b0;
        nmi_seen       <= 1'b0;
    end else begin
        exc_take       <= take_d;
        exc_vector     <= take_d ? `CETW_COMMON_VEC : 32'h0000_0000;
        exc_code       <= take_d ? code_d : exc_code;
        exc_epc        <= take_d ? epc_d : exc_epc;
        cache_err_take <= cache_err_req && !de && !error_level_flag;
        nmi_seen       <= nmi;
    end
end

endmodule // cetw_exc_unit

// file: sim/cetw_irq_model.sv
// interrupt controller model driving the request lines
`timescale 1ns/1ps
module cetw_irq_model (
    input  logic       hclk,
    input  logic       hresetn,
    input  logic [5:0] req_cmd,
    output logic [3:0] int_req,
    output logic       timer_irq,
    output logic       nmi
);
    // levels stay up until the controller itself drops them
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            {nmi, timer_irq, int_req} <= 6'h00;
        else
            {nmi, timer_irq, int_req} <= req_cmd;
    end
endmodule // cetw_irq_model

// file: sim/cetw_exc_unit_properties.sv
// port assertions for the exception unit
`timescale 1ns/1ps
`include "cetw_defs.vh"
module cetw_exc_props (
    input logic        hclk,
    input logic        hresetn,
    input logic        ex_valid,
    input logic [31:0] ex_pc,
    input logic        ex_in_delay_slot,
    input logic [31:0] ex_branch_pc,
    input logic [63:0] ex_op_a,
    input logic [63:0] ex_op_b,
    input logic        ex_is_trap,
    input logic [2:0]  ex_trap_cond,
    input logic        ex_ovf_check,
    input logic        ex_is_sub,
    input logic        ex_is_64,
    input logic        cache_err_req,
    input logic        exc_take,
    input logic [31:0] exc_vector,
    input logic [4:0]  exc_code,
    input logic [31:0] exc_epc,
    input logic        cache_err_take
);
    logic [63:0] sum;
    logic [31:0] epc_q;
    logic        trap_eq;
    logic        ovf;
    assign sum = ex_is_sub ? ex_op_a - ex_op_b : ex_op_a + ex_op_b;
    assign trap_eq = ex_valid && ex_is_trap && ex_trap_cond == `CETW_TC_EQ
                     && ex_op_a == ex_op_b;
    // sign position follows operand width
    assign ovf = ex_valid && ex_ovf_check && !ex_is_trap && (ex_is_64
        ? ex_op_a[63] == (ex_op_b[63] ^ ex_is_sub) && sum[63] != ex_op_a[63]
        : ex_op_a[31] == (ex_op_b[31] ^ ex_is_sub) && sum[31] != ex_op_a[31]);
    always @(posedge hclk) epc_q <= ex_in_delay_slot ? ex_branch_pc : ex_pc;
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    a_trap_taken: assert property (trap_eq |=> exc_take && exc_code == `CETW_EXC_TR)
        else $error("trap not taken");
    a_ovf_taken: assert property (ovf |=> exc_take && exc_code == `CETW_EXC_OV)
        else $error("overflow not taken");
    a_epc_slot: assert property (trap_eq || ovf |=> exc_epc == epc_q)
        else $error("wrong restart pc");
    a_vector_common: assert property (exc_vector == (exc_take ? `CETW_COMMON_VEC : 32'h0))
        else $error("wrong vector");
    a_code_holds: assert property (!exc_take |-> $stable(exc_code) && $stable(exc_epc))
        else $error("code moved without take");
    a_take_pulse: assert property (trap_eq ##1 !ex_valid |=> !exc_take)
        else $error("take repeated");
    a_ce_idle: assert property (!cache_err_req |=> !cache_err_take)
        else $error("cache error without request");
    a_ce_cause: assert property ($rose(cache_err_take) |-> $past(cache_err_req))
        else $error("cache error not caused");
    c_watch: cover property (exc_take && exc_code == `CETW_EXC_WATCH);
    c_int: cover property (exc_take && exc_code == `CETW_EXC_INT);
    c_ce: cover property (cache_err_take);
endmodule // cetw_exc_props
bind cetw_exc_unit cetw_exc_props u_props (.hclk, .hresetn, .ex_valid, .ex_pc,
    .ex_in_delay_slot, .ex_branch_pc, .ex_op_a, .ex_op_b, .ex_is_trap, .ex_trap_cond,
    .ex_ovf_check, .ex_is_sub, .ex_is_64, .cache_err_req, .exc_take, .exc_vector,
    .exc_code, .exc_epc, .cache_err_take);

// file: sim/cetw_tb.sv
// self-checking testbench for the exception unit
`timescale 1ns/1ps
`include "cetw_defs.vh"
module testbench;
    typedef struct {logic t; logic [2:0] c; logic o, s, w; logic [63:0] a, b;
        logic k; logic [4:0] e;} cetw_row_t;
    logic        hclk = '0, hresetn = '0, hsel = '0, hwrite = '0, hit;
    logic        hreadyout, hresp, timer_irq, nmi, exc_take, cache_err_take, nmi_seen;
    logic [1:0]  htrans = '0;
    logic [2:0]  hsize = 3'h2, ex_trap_cond = '0;
    logic [31:0] haddr = '0, hwdata = '0, ex_pc = '0, ex_branch_pc = '0;
    logic [31:0] hrdata, rd, exc_vector, exc_epc;
    logic        ex_valid = '0, ex_in_delay_slot = '0, ex_is_trap = '0, ex_ovf_check = '0;
    logic        ex_is_sub = '0, ex_is_64 = '0, mem_valid = '0, mem_is_load = '0;
    logic        mem_is_store = '0, mem_is_cache = '0, cache_err_req = '0;
    logic [63:0] ex_op_a = '0, ex_op_b = '0;
    logic [35:0] mem_paddr = '0;
    logic [3:0]  int_req;
    logic [4:0]  exc_code;
    logic [5:0]  req_cmd = '0;
    int          mismatches = 0, compares = 0;
    cetw_row_t   nil = '{default: '0};
    cetw_row_t   rows [10] = '{
        '{1, `CETW_TC_GE, 0, 0, 0, 64'h5, 64'h3, 1, `CETW_EXC_TR},
        '{1, `CETW_TC_GEU, 0, 0, 0, 64'h1, 64'hFFFF_FFFF_FFFF_FFFF, 0, 5'h00},
        '{1, `CETW_TC_LT, 0, 0, 0, 64'hFFFF_FFFF_FFFF_FFFF, 64'h0, 1, `CETW_EXC_TR},
        '{1, `CETW_TC_LTU, 0, 0, 0, 64'h1, 64'h2, 1, `CETW_EXC_TR},
        '{1, `CETW_TC_EQ, 0, 0, 0, 64'h7, 64'h7, 1, `CETW_EXC_TR},
        '{1, `CETW_TC_NE, 0, 0, 0, 64'h4, 64'h4, 0, 5'h00},
        '{0, 3'h0, 1, 0, 0, 64'h7FFF_FFFF, 64'h1, 1, `CETW_EXC_OV},
        '{0, 3'h0, 1, 0, 1, 64'h7FFF_FFFF, 64'h1, 0, 5'h00},
        '{0, 3'h0, 1, 1, 1, 64'h8000_0000_0000_0000, 64'h1, 1, `CETW_EXC_OV},
        '{0, 3'h0, 1, 0, 0, 64'h1, 64'h1, 0, 5'h00}};
    // paddr, {load, store, cache}, take expected
    logic [39:0] wrows [5] = '{{36'h1_0000_1234, 3'h2, 1'b0}, {36'h1_0000_1230, 3'h5, 1'b0},
        {36'h0_0000_1230, 3'h4, 1'b0}, {36'h1_0000_1237, 3'h4, 1'b1},
        {36'h1_0000_1230, 3'h4, 1'b0}};
    logic [31:0] masks [4] = '{32'h0000_FB01, 32'h0000_FF00, 32'h0000_FF03, 32'h0000_FF05};
    logic [31:0] ce [3] = '{32'h0001_0000, 32'h0000_0004, 32'h0000_0000};

    cetw_exc_unit DUT (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready(hreadyout), .hreadyout, .hrdata, .hresp, .ex_valid, .ex_pc,
        .ex_in_delay_slot, .ex_branch_pc, .ex_op_a, .ex_op_b, .ex_is_trap, .ex_trap_cond,
        .ex_ovf_check, .ex_is_sub, .ex_is_64, .mem_valid, .mem_is_load, .mem_is_store,
        .mem_is_cache, .mem_paddr, .int_req, .timer_irq, .nmi, .cache_err_req, .exc_take,
        .exc_vector, .exc_code, .exc_epc, .cache_err_take, .nmi_seen);
    cetw_irq_model u_irq (.hclk, .hresetn, .req_cmd, .int_req, .timer_irq, .nmi);

    always #5 hclk = ~hclk;

    // ----
    // tasks
    // ----
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, a};
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rd = hrdata;
    endtask
    task automatic issue(input cetw_row_t r, input logic [2:0] m);
        @(posedge hclk);
        ex_valid <= 1'b1;
        {ex_is_trap, ex_trap_cond, ex_ovf_check, ex_is_sub, ex_is_64} <= {r.t, r.c, r.o, r.s, r.w};
        {ex_op_a, ex_op_b} <= {r.a, r.b};
        {mem_valid, mem_is_load, mem_is_store, mem_is_cache} <= {|m, m};
        @(posedge hclk);
        {ex_valid, ex_is_trap, ex_ovf_check, mem_valid} <= 4'h0;
        #1;
    endtask
    task automatic wait_hit(input logic sel_ce, input int n);
        hit = 1'b0;
        repeat (n) begin
            @(posedge hclk);
            #1;
            if ((sel_ce ? cache_err_take : exc_take) === 1'b1) hit = 1'b1;
        end
    endtask
    task automatic final_report;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // ----
    // sequence
    // ----
    initial begin
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        bus(1'b0, `CETW_OFS_STATUS, '0);
        chk(rd, `CETW_STATUS_RST);
        foreach (rows[i]) begin
            issue(rows[i], 3'h0);
            chk(exc_take, rows[i].k);
            if (rows[i].k) chk(exc_code, rows[i].e);
        end
        ex_pc <= 32'h0000_0100;
        ex_branch_pc <= 32'h0000_00FC;
        ex_in_delay_slot <= 1'b1;
        issue(rows[4], 3'h0);
        chk(exc_epc, 32'h0000_00FC);
        ex_in_delay_slot <= 1'b0;
        bus(1'b0, `CETW_OFS_CAUSE, '0);
        chk(rd[31], 1'b1);
        bus(1'b1, `CETW_OFS_WATCH_LO, 32'h0000_1232);
        bus(1'b1, `CETW_OFS_WATCH_HI, 32'h0000_0001);
        bus(1'b1, `CETW_OFS_STATUS, '0);
        foreach (wrows[i]) begin
            mem_paddr <= wrows[i][39:4];
            issue(nil, wrows[i][3:1]);
            chk(exc_take, wrows[i][0]);
        end
        chk(exc_code, `CETW_EXC_WATCH);
        bus(1'b1, `CETW_OFS_STATUS, '0);
        wait_hit(1'b0, 4);
        chk(hit, 1'b1);
        bus(1'b1, `CETW_OFS_WATCH_LO, 32'h0000_1231);
        bus(1'b1, `CETW_OFS_STATUS, '0);
        issue(nil, 3'h2);
        chk(exc_take, 1'b1);
        for (int i = 0; i < 5; i++) begin
            bus(1'b1, `CETW_OFS_STATUS, 32'h0000_FF01);
            req_cmd <= 6'h01 << i;
            wait_hit(1'b0, 6);
            chk(hit, 1'b1);
            chk(exc_code, `CETW_EXC_INT);
            bus(1'b0, `CETW_OFS_CAUSE, '0);
            chk(rd[15:8], i < 4 ? 8'h04 << i : 8'h80);
            req_cmd <= '0;
        end
        req_cmd <= 6'h1F;
        bus(1'b0, `CETW_OFS_CAUSE, '0);
        chk(rd[15:8], 8'hBC);
        req_cmd <= '0;
        bus(1'b0, `CETW_OFS_CAUSE, '0);
        chk(rd[15:8], 8'h00);
        foreach (masks[i]) begin
            bus(1'b1, `CETW_OFS_STATUS, masks[i]);
            req_cmd <= 6'h01;
            wait_hit(1'b0, 6);
            chk(hit, 1'b0);
        end
        req_cmd <= '0;
        for (int i = 0; i < 2; i++) begin
            bus(1'b1, `CETW_OFS_STATUS, 32'h0000_FF01);
            bus(1'b1, `CETW_OFS_CAUSE, 32'h0000_0100 << i);
            wait_hit(1'b0, 4);
            chk(hit, 1'b1);
            bus(1'b1, `CETW_OFS_CAUSE, '0);
            bus(1'b0, `CETW_OFS_CAUSE, '0);
            chk(rd[15:8], 8'h00);
        end
        foreach (ce[i]) begin
            bus(1'b1, `CETW_OFS_STATUS, ce[i]);
            cache_err_req <= 1'b1;
            wait_hit(1'b1, 4);
            chk(hit, i == 2);
            cache_err_req <= 1'b0;
        end
        req_cmd <= 6'h20;
        repeat (3) @(posedge hclk);
        #1;
        chk(nmi_seen, 1'b1);
        final_report();
    end

    // whole run needs well under a thousand cycles
    initial begin
        #100000;
        mismatches++;
        final_report();
    end
endmodule // testbench
